// >>> itv_pkg.sv
// package of constants and types for the interrupt and trap vector unit
package itv_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int ITV_NUM_SRC = 32;
  localparam int ITV_NUM_CAPT_CH = 16;
  localparam int ITV_PRIO_W = 4;
  localparam int ITV_TRAP_W = 7;
  localparam int ITV_VEC_W = 9;
  localparam int ITV_NUM_B = 5;
  localparam int ITV_SP_W = 16;

  // ------------------------------------------------------------
  // trap numbers
  // ------------------------------------------------------------
  localparam logic [6:0] ITV_TRAP_RESET = 7'h00;
  localparam logic [6:0] ITV_TRAP_NMI = 7'h02;
  localparam logic [6:0] ITV_TRAP_STKO = 7'h04;
  localparam logic [6:0] ITV_TRAP_STKU = 7'h06;
  localparam logic [6:0] ITV_TRAP_CLASSB = 7'h0a;
  localparam logic [6:0] ITV_TRAP_RSV_LO = 7'h0b;
  localparam logic [6:0] ITV_TRAP_RSV_HI = 7'h0f;
  localparam logic [6:0] ITV_TRAP_SRC0 = 7'h10;
  localparam logic [6:0] ITV_TRAP_SRC_LAST = 7'h2f;
  localparam logic [6:0] ITV_TRAP_SW_MAX = 7'h7f;
  localparam logic [1:0] ITV_VEC_SHIFT = 2'h2;

  // ------------------------------------------------------------
  // trap priority levels, and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] ITV_TPRIO_NONE = 2'h0;
  localparam logic [1:0] ITV_TPRIO_B = 2'h1;
  localparam logic [1:0] ITV_TPRIO_A = 2'h2;
  localparam logic [15:0] ITV_CAUSE_RST = 16'h0000;

  // trap cause register bit positions
  localparam int ITV_BIT_BADOPC = 0;
  localparam int ITV_BIT_BADFETCH = 1;
  localparam int ITV_BIT_NOBUS = 2;
  localparam int ITV_BIT_MISALIGN = 3;
  localparam int ITV_BIT_GUARDED = 7;
  localparam int ITV_BIT_STKU = 13;
  localparam int ITV_BIT_STKO = 14;
  localparam int ITV_BIT_NMI = 15;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ITV_IDLE = 2'b00,
    ITV_INT_SVC = 2'b01,
    ITV_TRAP_SVC = 2'b11
  } itv_state_t;

  typedef struct packed {
    logic bad_opcode;
    logic guarded_instr_fault;
    logic misaligned_word;
    logic bad_fetch;
    logic no_bus_access;
  } itv_classb_t;

  typedef struct packed {
    logic valid;
    logic [6:0] trap_num;
    logic [8:0] vector;
    logic is_hw_trap;
  } itv_branch_t;
endpackage : itv_pkg

// >>> itv_unit.sv
// interrupt and trap vector unit: arbitration, vectoring and trap cause register
`timescale 1ns/1ps
// Summary of operation
// - each of 32 sources has a request and enable flag and its own vector, 40h..bch, trap numbers 10h..2fh.
// - hardware reset, software reset and watchdog overflow all vector to 0000h with trap number 00h.
// - nmi, stack overflow and stack underflow vector to 0008h, 0010h and 0018h (traps 02h, 04h, 06h).
// - all five class b causes share vector 0028h, trap 0ah, at trap priority 1.
// - each class b cause sets its own distinct flag bit in the trap cause register.
// - a software trap selects trap 00h..7fh, vector number times four, at the current cpu priority.
// - a hardware trap is taken at once, no mask blocks it, and branches like an interrupt.
// - a hardware trap sets its own bit in the trap cause register.
// - a hardware trap preempts any program or interrupt unless a trap service of the same or higher trap priority runs.
// - during a hardware trap service, interrupts and event transfers are not accepted.
// - each source has a four bit priority; a service is preempted only by a higher priority.
// - the stack pointer is compared to upper and lower limits on each stack access, raising class a traps.
module itv_unit (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // reset sources
  input wire logic sw_reset,
  input wire logic watchdog_overflow,
  // peripheral interrupt sources
  input wire logic [itv_pkg::ITV_NUM_SRC-1:0] src_request,
  input wire logic [itv_pkg::ITV_NUM_SRC-1:0] src_enable,
  input wire logic [itv_pkg::ITV_NUM_SRC*itv_pkg::ITV_PRIO_W-1:0] src_priority,
  input wire logic global_int_enable,
  input wire logic [itv_pkg::ITV_PRIO_W-1:0] cpu_priority,
  // exception detectors
  input wire logic nmi_pin,
  input wire itv_pkg::itv_classb_t classb_fault,
  input wire logic stack_access,
  input wire logic [itv_pkg::ITV_SP_W-1:0] stack_pointer,
  input wire logic [itv_pkg::ITV_SP_W-1:0] stack_upper_limit,
  input wire logic [itv_pkg::ITV_SP_W-1:0] stack_lower_limit,
  // software trap
  input wire logic sw_trap,
  input wire logic [itv_pkg::ITV_TRAP_W-1:0] sw_trap_num,
  // core service handshake
  input wire logic service_return,
  input wire logic [itv_pkg::ITV_NUM_SRC-1:0] cause_clear,
  // branch request to core
  output itv_pkg::itv_branch_t branch,
  output logic [itv_pkg::ITV_PRIO_W-1:0] branch_priority,
  output logic int_ack_valid,
  output logic [4:0] int_ack_src,
  output logic trap_service_active,
  output logic event_xfer_block,
  // trap cause register
  output logic [15:0] trap_cause_register
);
  import itv_pkg::*;

  // ------------------------------------------------------------
  // nmi pin synchroniser
  // ------------------------------------------------------------
  logic nmi_s1_reg, nmi_s1_next;
  logic nmi_s2_reg, nmi_s2_next;
  logic nmi_s3_reg, nmi_s3_next;
  logic nmi_edge;

  // nmi is taken on its falling edge, seen after two flops
  always_comb begin
    nmi_s1_next = nmi_pin;
    nmi_s2_next = nmi_s1_reg;
    nmi_s3_next = nmi_s2_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nmi_s1_reg <= 1'b1;
      nmi_s2_reg <= 1'b1;
      nmi_s3_reg <= 1'b1;
    end else begin
      nmi_s1_reg <= nmi_s1_next;
      nmi_s2_reg <= nmi_s2_next;
      nmi_s3_reg <= nmi_s3_next;
    end
  end

  assign nmi_edge = nmi_s3_reg & ~nmi_s2_reg;

  // ------------------------------------------------------------
  // hardware trap detection
  // ------------------------------------------------------------
  logic stk_over, stk_under, any_b, any_a;
  logic [15:0] trap_set;

  // limits are checked on every stack access
  assign stk_over = stack_access && (stack_pointer < stack_upper_limit);
  assign stk_under = stack_access && (stack_pointer > stack_lower_limit);
  assign any_b = |classb_fault;
  assign any_a = nmi_edge | stk_over | stk_under;

  // one distinct bit per cause
  always_comb begin
    trap_set = 16'h0000;
    trap_set[ITV_BIT_NMI] = nmi_edge;
    trap_set[ITV_BIT_STKO] = stk_over;
    trap_set[ITV_BIT_STKU] = stk_under;
    trap_set[ITV_BIT_BADOPC] = classb_fault.bad_opcode;
    trap_set[ITV_BIT_GUARDED] = classb_fault.guarded_instr_fault;
    trap_set[ITV_BIT_MISALIGN] = classb_fault.misaligned_word;
    trap_set[ITV_BIT_BADFETCH] = classb_fault.bad_fetch;
    trap_set[ITV_BIT_NOBUS] = classb_fault.no_bus_access;
  end

  // ------------------------------------------------------------
  // interrupt arbitration: highest priority, lowest index on ties
  // ------------------------------------------------------------
  logic win_valid;
  logic [4:0] win_idx;
  logic [3:0] win_prio;

  always_comb begin
    win_valid = 1'b0;
    win_idx = 5'h00;
    win_prio = 4'h0;
    for (int i = 0; i < ITV_NUM_SRC; i++) begin
      // a service is preempted only by a strictly higher level
      if (src_request[i] && src_enable[i] && (src_priority[i*ITV_PRIO_W +: ITV_PRIO_W] > cpu_priority) &&
          (!win_valid || (src_priority[i*ITV_PRIO_W +: ITV_PRIO_W] > win_prio))) begin
        win_valid = 1'b1;
        win_idx = 5'(i);
        win_prio = src_priority[i*ITV_PRIO_W +: ITV_PRIO_W];
      end
    end
  end

  // ------------------------------------------------------------
  // service state and branch selection
  // ------------------------------------------------------------
  itv_state_t state_reg, state_next;
  logic [1:0] tprio_reg, tprio_next;
  itv_branch_t branch_reg, branch_next;
  logic [3:0] bprio_reg, bprio_next;
  logic ack_reg, ack_next;
  logic [4:0] ack_src_reg, ack_src_next;
  logic [15:0] cause_reg, cause_next;
  logic [1:0] new_tprio;
  logic [6:0] num;
  logic tsvc_reg, tsvc_next;

  assign new_tprio = any_a ? ITV_TPRIO_A : (any_b ? ITV_TPRIO_B : ITV_TPRIO_NONE);

  always_comb begin
    state_next = state_reg;
    tprio_next = tprio_reg;
    branch_next = '0;
    bprio_next = bprio_reg;
    ack_next = 1'b0;
    ack_src_next = ack_src_reg;
    num = ITV_TRAP_RESET;
    // set wins over clear on the same cycle
    cause_next = (cause_reg & ~cause_clear[15:0]) | trap_set;
    if (service_return) begin
      state_next = ITV_IDLE;
      tprio_next = ITV_TPRIO_NONE;
    end
    if (sw_reset || watchdog_overflow) begin
      // reset vector, trap 00h
      num = ITV_TRAP_RESET;
      branch_next = '{1'b1, num, {num, ITV_VEC_SHIFT'(2'h0)}, 1'b0};
      state_next = ITV_IDLE;
      tprio_next = ITV_TPRIO_NONE;
    end else if (new_tprio > tprio_reg) begin
      // no mask or enable gates this path
      if (nmi_edge) num = ITV_TRAP_NMI;
      else if (stk_over) num = ITV_TRAP_STKO;
      else if (stk_under) num = ITV_TRAP_STKU;
      else num = ITV_TRAP_CLASSB;
      branch_next = '{1'b1, num, {num, 2'b00}, 1'b1};
      state_next = ITV_TRAP_SVC;
      tprio_next = new_tprio;
    end else if (sw_trap) begin
      // software trap keeps the cpu priority and is no trap service
      num = sw_trap_num & ITV_TRAP_SW_MAX;
      branch_next = '{1'b1, num, {num, 2'b00}, 1'b0};
      bprio_next = cpu_priority;
    end else if (win_valid && global_int_enable && state_reg != ITV_TRAP_SVC) begin
      num = 7'(ITV_TRAP_SRC0 + 7'(win_idx));
      branch_next = '{1'b1, num, {num, 2'b00}, 1'b0};
      bprio_next = win_prio;
      ack_next = 1'b1;
      ack_src_next = win_idx;
      state_next = ITV_INT_SVC;
    end
    // registered copy, so the status outputs come straight from a flop
    tsvc_next = (state_next == ITV_TRAP_SVC);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ITV_IDLE;
      tprio_reg <= ITV_TPRIO_NONE;
      // hardware reset issues the reset vector, trap 00h
      branch_reg <= '{1'b1, ITV_TRAP_RESET, 9'h000, 1'b0};
      bprio_reg <= 4'h0;
      ack_reg <= 1'b0;
      ack_src_reg <= 5'h00;
      cause_reg <= ITV_CAUSE_RST;
      tsvc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tprio_reg <= tprio_next;
      branch_reg <= branch_next;
      bprio_reg <= bprio_next;
      ack_reg <= ack_next;
      ack_src_reg <= ack_src_next;
      cause_reg <= cause_next;
      tsvc_reg <= tsvc_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------
  assign branch = branch_reg;
  assign branch_priority = bprio_reg;
  assign int_ack_valid = ack_reg;
  assign int_ack_src = ack_src_reg;
  assign trap_service_active = tsvc_reg;
  assign event_xfer_block = tsvc_reg;
  assign trap_cause_register = cause_reg;
endmodule : itv_unit

// >>> itv_core_model.sv
// core side model: ends the service a fixed time after the latest branch
`timescale 1ns/1ps
module itv_core_model #(
  parameter int RET = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // branch in, return out
  input wire itv_pkg::itv_branch_t branch,
  output logic service_return
);
  import itv_pkg::*;
  // ----
  // handler timer
  // ----
  int cnt;
  // a new branch restarts the handler, so nested services return once
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 0;
      service_return <= 1'b0;
    end else begin
      service_return <= (cnt == 1);
      if (branch.valid) cnt <= RET;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : itv_core_model

// >>> itv_unit_sva.sv
// assertions on the ports of the vector unit
`timescale 1ns/1ps
module itv_unit_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // causes
  input wire logic sw_reset,
  input wire logic nmi_pin,
  input wire itv_pkg::itv_classb_t classb_fault,
  input wire logic stack_access,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] stack_upper_limit,
  input wire logic service_return,
  // results
  input wire itv_pkg::itv_branch_t branch,
  input wire logic int_ack_valid,
  input wire logic [4:0] int_ack_src,
  input wire logic trap_service_active,
  input wire logic [15:0] trap_cause_register
);
  import itv_pkg::*;
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic quiet;
  // no software reset or stack access competes in the same cycle
  assign quiet = !sw_reset && !stack_access;
  a_classb_vector: assert property (|classb_fault && quiet && !trap_service_active |=>
    branch.valid && branch.trap_num == 7'h0a && branch.vector == 9'h028) else $error("class b vector");
  a_reset_vector: assert property (sw_reset |=>
    branch.valid && branch.trap_num == 7'h00 && branch.vector == 9'h000) else $error("reset vector");
  a_vector_scale: assert property (branch.valid |-> branch.vector == {branch.trap_num, 2'b00})
    else $error("vector not four times trap");
  a_reserved_unused: assert property (branch.valid && branch.is_hw_trap |->
    !(branch.trap_num inside {[7'h0b:7'h0f]})) else $error("reserved trap issued");
  a_cause_own_bit: assert property (classb_fault.bad_opcode |=> trap_cause_register[0])
    else $error("opcode cause bit");
  a_stack_over: assert property (stack_access && stack_pointer < stack_upper_limit |=>
    trap_cause_register[14]) else $error("stack over bit");
  a_trap_blocks_int: assert property (trap_service_active && !service_return && !sw_reset |=>
    !int_ack_valid) else $error("interrupt inside trap");
  a_nmi_taken: assert property ($fell(nmi_pin) && !trap_service_active |->
    ##[1:4] (branch.valid && branch.trap_num == 7'h02)) else $error("nmi not taken");
  a_ack_vector: assert property (int_ack_valid |->
    branch.valid && branch.trap_num == 7'h10 + int_ack_src) else $error("ack vector");
  c_classb: cover property (branch.valid && branch.trap_num == 7'h0a);
  c_int: cover property (int_ack_valid);
  c_nmi: cover property (branch.valid && branch.trap_num == 7'h02);
endmodule : itv_unit_sva

// >>> tb_itv_unit.sv
// self-checking bench of the vector unit
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module tb_itv_unit;
  import itv_pkg::*;
  // ----
  // signals
  // ----
  logic clk = 1'b0;
  logic reset, sw_reset, watchdog_overflow, global_int_enable, nmi_pin, stack_access, sw_trap, service_return;
  logic [31:0] src_request, src_enable, cause_clear;
  logic [127:0] src_priority;
  logic [3:0] cpu_priority, branch_priority;
  itv_classb_t classb_fault;
  logic [15:0] stack_pointer, stack_upper_limit, stack_lower_limit, trap_cause_register;
  logic [6:0] sw_trap_num;
  itv_branch_t branch;
  logic int_ack_valid, trap_service_active, event_xfer_block;
  logic [4:0] int_ack_src;
  int mismatches = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  itv_unit itv_unit_inst (.clk, .reset, .sw_reset, .watchdog_overflow, .src_request, .src_enable, .src_priority,
    .global_int_enable, .cpu_priority, .nmi_pin, .classb_fault, .stack_access, .stack_pointer, .stack_upper_limit,
    .stack_lower_limit, .sw_trap, .sw_trap_num, .service_return, .cause_clear, .branch, .branch_priority,
    .int_ack_valid, .int_ack_src, .trap_service_active, .event_xfer_block, .trap_cause_register);
  itv_core_model itv_core_model_inst (.clk, .reset, .branch, .service_return);
  // ----
  // helpers
  // ----
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic print_verdict();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // bounded wait, so a missing branch ends the run instead of hanging
  task automatic expect_br(input logic [6:0] t);
    int i;
    for (i = 0; branch.valid !== 1'b1 && i < 8; i++) step();
    if (i == 8) mismatches++;
    if (i == 8) print_verdict();
    `CHK("trap_num", t, branch.trap_num)
    `CHK("vector", {t, 2'b00}, branch.vector)
  endtask : expect_br
  task automatic idle_clear();
    int i;
    for (i = 0; trap_service_active !== 1'b0 && i < 64; i++) step();
    if (i == 64) mismatches++;
    if (i == 64) print_verdict();
    `CHK("xfer_free", 1'b0, event_xfer_block)
    cause_clear = 32'h0000ffff;
    step();
    cause_clear = '0;
  endtask : idle_clear
  // ----
  // scenarios
  // ----
  task automatic t_resets();
    `CHK("reset_valid", 1'b1, branch.valid)
    `CHK("cause_rst", ITV_CAUSE_RST, trap_cause_register)
    reset = 1'b0;
    step();
    sw_reset = 1'b1;
    step();
    sw_reset = 1'b0;
    watchdog_overflow = 1'b1;
    expect_br(ITV_TRAP_RESET);
    step();
    watchdog_overflow = 1'b0;
    expect_br(ITV_TRAP_RESET);
    idle_clear();
  endtask : t_resets
  task automatic t_classb();
    int pos[5] = '{ITV_BIT_BADOPC, ITV_BIT_GUARDED, ITV_BIT_MISALIGN, ITV_BIT_BADFETCH, ITV_BIT_NOBUS};
    for (int k = 0; k < 5; k++) begin
      classb_fault = itv_classb_t'(5'h10 >> k);
      step();
      classb_fault = '0;
      expect_br(ITV_TRAP_CLASSB);
      `CHK("cause_b", 16'h0001 << pos[k], trap_cause_register)
      `CHK("hw_trap", 1'b1, branch.is_hw_trap)
      `CHK("trap_active", 1'b1, trap_service_active)
      `CHK("xfer_block", 1'b1, event_xfer_block)
      idle_clear();
    end
  endtask : t_classb
  task automatic t_class_a(input logic [15:0] sp, input logic nmi, input logic [6:0] t, input int b);
    if (nmi) nmi_pin = 1'b0;
    stack_pointer = sp;
    stack_access = !nmi;
    step();
    stack_access = 1'b0;
    expect_br(t);
    `CHK("cause_a", 1'b1, trap_cause_register[b])
    nmi_pin = 1'b1;
    stack_pointer = 16'h0240;
    idle_clear();
  endtask : t_class_a
  task automatic t_swtrap();
    logic [6:0] tl[3] = '{7'h7f, 7'h0b, 7'h21};
    cpu_priority = 4'h5;
    for (int k = 0; k < 3; k++) begin
      sw_trap_num = tl[k];
      sw_trap = 1'b1;
      step();
      sw_trap = 1'b0;
      expect_br(tl[k]);
      `CHK("sw_prio", 4'h5, branch_priority)
      repeat (16) step();
    end
  endtask : t_swtrap
  // lower level source loses; a trap preempts the service and holds off a later request
  task automatic t_irq();
    int i;
    cpu_priority = 4'h7;
    src_priority[3:0] = 4'h2;
    src_priority[23:20] = 4'h9;
    src_priority[127:124] = 4'hf;
    src_enable = 32'hffffffdf;
    src_request = 32'h00000020;
    step();
    `CHK("masked_src", 1'b0, branch.valid)
    src_enable = '1;
    global_int_enable = 1'b0;
    step();
    `CHK("masked_global", 1'b0, branch.valid)
    global_int_enable = 1'b1;
    src_request = 32'h00000021;
    expect_br(7'h15);
    `CHK("ack_valid", 1'b1, int_ack_valid)
    `CHK("ack_src", 5'h05, int_ack_src)
    src_request = '0;
    classb_fault.no_bus_access = 1'b1;
    step();
    classb_fault = '0;
    expect_br(ITV_TRAP_CLASSB);
    src_request = 32'h80000000;
    for (i = 0; trap_service_active === 1'b1 && i < 64; i++) begin
      `CHK("ack_in_trap", 1'b0, int_ack_valid)
      step();
    end
    if (i == 64) mismatches++;
    expect_br(ITV_TRAP_SRC_LAST);
    `CHK("ack_src", 5'h1f, int_ack_src)
    src_request = '0;
    idle_clear();
  endtask : t_irq
  // ----
  // main sequence
  // ----
  initial begin
    {reset, nmi_pin, global_int_enable} = 3'h7;
    {sw_reset, watchdog_overflow, stack_access, sw_trap} = 4'h0;
    {src_request, cause_clear, src_priority, sw_trap_num, classb_fault} = '0;
    src_enable = '1;
    cpu_priority = 4'h0;
    stack_pointer = 16'h0240;
    stack_upper_limit = 16'h0200;
    stack_lower_limit = 16'h0280;
    repeat (16) step();
    t_resets();
    t_classb();
    t_class_a(16'h0100, 1'b0, ITV_TRAP_STKO, ITV_BIT_STKO);
    t_class_a(16'h0300, 1'b0, ITV_TRAP_STKU, ITV_BIT_STKU);
    t_class_a(16'h0240, 1'b1, ITV_TRAP_NMI, ITV_BIT_NMI);
    t_swtrap();
    t_irq();
    print_verdict();
  end
endmodule : tb_itv_unit
bind itv_unit itv_unit_sva itv_unit_sva_inst (.clk, .reset, .sw_reset, .nmi_pin, .classb_fault, .stack_access,
  .stack_pointer, .stack_upper_limit, .service_return, .branch, .int_ack_valid, .int_ack_src,
  .trap_service_active, .trap_cause_register);
